// ---- include/twtrs_consts.svh ----
// Operation
// [RULE_01] Eighteen-bit word splits over three channels, each with own buffer and shifter bits.
// [RULE_02] Host strobe loads buffer; interchange moves it to shifter; shifter shifts toward writers. The code gives no shift pulse in write mode.
// [RULE_03] Each read shift pulse loads reader bit; six bits per channel make a word.
// [RULE_04] One interchange pulse swaps buffer and shift register contents together.
// [RULE_05] After a read interchange all eighteen buffer bits go to the host.
// [RULE_06] Search mode sets data flag at time pulse 2 on a block mark.
// [RULE_07] Every raise-data-flag pulse also interchanges; search puts block number in buffer.
// [RULE_08] Search mode with writers off shifts right at time pulse 1, any direction.
// [RULE_09] Read mode raises data flag at time pulse 2 on read-data mark, then interchanges.
// [RULE_10] Read-data mark covers reverse check, last two starts, data, prefinal, final.
// [RULE_11] Read delivers reverse check word first and check-sum word last.
// [RULE_12] Read mode check mark sets block flag at time pulse 2, reported as status.
// [RULE_13] Interchange happens whenever data flag or block flag is raised.
// [RULE_14] Not writing, writers off, forward tape: shift right at time pulse 1.
// [RULE_15] Reverse tape, not write or search, writers off: shift left at time pulse 1.
// [RULE_16] Raise-data-flag pulse sets data flag flip-flop reported to host as status.
// [RULE_17] Write mode write-data mark on starts and data marks requests a buffer load.
// [RULE_18] Host must service buffer and flags before the next mark flag, else word lost.
`ifndef TWTRS_CONSTS_SVH
`define TWTRS_CONSTS_SVH
`define TWTRS_WORD_W      18
`define TWTRS_CHAN_N      3
`define TWTRS_CHAN_W      6
`define TWTRS_OFF_CTRL    32'h0000_0000
`define TWTRS_OFF_STATUS  32'h0000_0004
`define TWTRS_OFF_MASK    32'h0000_0008
`define TWTRS_OFF_BUFFER  32'h0000_000C
`define TWTRS_OFF_SHIFT   32'h0000_0010
`define TWTRS_CTRL_MODE   1:0
`define TWTRS_CTRL_WRON   2
`define TWTRS_CTRL_REV    3
`define TWTRS_ST_DATA     0
`define TWTRS_ST_BLOCK    1
`define TWTRS_RST_WORD    18'h0_0000
`endif

// ---- include/twtrs_pkg.sv ----
package twtrs_pkg;
   typedef enum logic [1:0] {
      TWTRS_IDLE   = 2'b00,
      TWTRS_SEARCH = 2'b01,
      TWTRS_READ   = 2'b11,
      TWTRS_WRITE  = 2'b10
   } twtrs_mode_t;
endpackage

// ---- include/twtrs_xfer_if.sv ----
`timescale 1ns/1ps
interface twtrs_xfer_if;
   logic        load;
   logic [17:0] load_data;
   logic        interchange;
   logic        shift_right;
   logic        shift_left;
   logic [2:0]  reader_bits;
   logic [17:0] buffer_word;
   logic [17:0] shift_word;
   modport ctrl (output load, load_data, interchange, shift_right, shift_left,
                 reader_bits, input buffer_word, shift_word);
   modport path (input load, load_data, interchange, shift_right, shift_left,
                 reader_bits, output buffer_word, shift_word);
endinterface

// ---- verilog/twtrs_channel.sv ----
`timescale 1ns/1ps
`include "twtrs_consts.svh"
module twtrs_channel (
   // Clock and reset.
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control.
   input  wire logic       load,
   input  wire logic [5:0] load_data,
   input  wire logic       interchange,
   input  wire logic       shift_right,
   input  wire logic       shift_left,
   input  wire logic       reader_bit,
   // State.
   output logic [5:0]      buffer_bits,
   output logic [5:0]      shift_bits
);
   logic [5:0] buffer_nxt;
   logic [5:0] shift_nxt;

   // The swap reads both old values, so one edge exchanges them. [RULE_04]
   assign buffer_nxt = interchange ? shift_bits :
                       load        ? load_data  : buffer_bits; // [RULE_02]
   // Shift pulses bring in the reader bit; write mode gets no shift pulse, so the writers see a held shift register.
   assign shift_nxt  = interchange ? buffer_bits :
                       shift_right ? {reader_bit, shift_bits[5:1]} :
                       shift_left  ? {shift_bits[4:0], reader_bit} : shift_bits; // [RULE_03]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buffer_bits <= 6'h00;
         shift_bits  <= 6'h00;
      end else begin
         buffer_bits <= buffer_nxt;
         shift_bits  <= shift_nxt;
      end
   end
endmodule

// ---- verilog/twtrs_datapath.sv ----
`timescale 1ns/1ps
`include "twtrs_consts.svh"
module twtrs_datapath (
   // Clock and reset.
   input  wire logic pclk,
   input  wire logic presetn,
   // Control side.
   twtrs_xfer_if.path xf
);
   // Each channel owns every third bit, as the heads interleave them. [RULE_01]
   genvar c;
   generate
      for (c = 0; c < `TWTRS_CHAN_N; c++) begin : g_chan
         logic [5:0] ld;
         logic [5:0] bb;
         logic [5:0] sb;
         for (genvar b = 0; b < `TWTRS_CHAN_W; b++) begin : g_bit
            assign ld[b] = xf.load_data[b*3+c];
            assign xf.buffer_word[b*3+c] = bb[b];
            assign xf.shift_word[b*3+c]  = sb[b];
         end
         twtrs_channel u_chan (
            .pclk        (pclk),
            .presetn     (presetn),
            .load        (xf.load),
            .load_data   (ld),
            .interchange (xf.interchange),
            .shift_right (xf.shift_right),
            .shift_left  (xf.shift_left),
            .reader_bit  (xf.reader_bits[c]),
            .buffer_bits (bb),
            .shift_bits  (sb)
         );
      end
   endgenerate
endmodule

// ---- verilog/twtrs_top.sv ----
`timescale 1ns/1ps
`include "twtrs_consts.svh"
module twtrs_top (
   // APB slave.
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Timing and mark track.
   input  wire logic        time_pulse_1,
   input  wire logic        time_pulse_2,
   input  wire logic        block_mark,
   input  wire logic        read_data_mark,
   input  wire logic        write_data_mark,
   input  wire logic        check_mark,
   // Heads.
   input  wire logic [2:0]  reader_bits,
   output logic [2:0]       writer_bits,
   // Interrupt.
   output logic             irq
);
   // Pin synchronisers; logic reads stage two, and the stage after it for the time pulse edges.
   logic [8:0] pin_s1_r;
   logic [8:0] pin_s2_r;
   logic [8:0] pin_prev_r;
   wire  [8:0] pin_raw = {reader_bits, check_mark, write_data_mark,
                          read_data_mark, block_mark, time_pulse_2, time_pulse_1};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_r   <= 9'h000;
         pin_s2_r   <= 9'h000;
         pin_prev_r <= 9'h000;
      end else begin
         pin_s1_r   <= pin_raw;
         pin_s2_r   <= pin_s1_r;
         pin_prev_r <= pin_s2_r;
      end
   end
   // Time pulses are levels on pins; one action per pulse, on the rising edge.
   wire tp1  = pin_s2_r[0] & ~pin_prev_r[0];
   wire tp2  = pin_s2_r[1] & ~pin_prev_r[1];
   wire bm   = pin_s2_r[2];
   wire rdm  = pin_s2_r[3];
   wire wdm  = pin_s2_r[4];
   wire chk  = pin_s2_r[5];
   wire [2:0] rd_bits = pin_s2_r[8:6];

   // Control register.
   logic [3:0] ctrl_r;
   logic [1:0] status_r;
   logic [1:0] mask_r;
   twtrs_pkg::twtrs_mode_t mode;
   assign mode = twtrs_pkg::twtrs_mode_t'(ctrl_r[`TWTRS_CTRL_MODE]);
   wire writers_on        = ctrl_r[`TWTRS_CTRL_WRON];
   wire reverse_direction = ctrl_r[`TWTRS_CTRL_REV];
   wire in_search = (mode == twtrs_pkg::TWTRS_SEARCH);
   wire in_read   = (mode == twtrs_pkg::TWTRS_READ);
   wire in_write  = (mode == twtrs_pkg::TWTRS_WRITE);

   // Flag raising.
   wire search_flag = in_search & bm & tp2;            // [RULE_06]
   // The read-data mark already spans reverse check through final. [RULE_10] [RULE_11]
   wire read_flag   = in_read & rdm & tp2;             // [RULE_09]
   wire write_flag  = in_write & wdm & tp2;            // [RULE_17]
   wire raise_data_flag_pulse  = search_flag | read_flag | write_flag;
   wire raise_block_flag_pulse = in_read & chk & tp2;  // [RULE_12]
   // Both flags drive the swap, so the buffer holds the new word with the flag. [RULE_07] [RULE_13]
   wire interchange_pulse = raise_data_flag_pulse | raise_block_flag_pulse;

   // Shift pulses.
   wire shift_search      = in_search & ~writers_on & tp1;                       // [RULE_08]
   wire shift_fwd         = ~in_write & ~in_search & ~writers_on & ~reverse_direction & tp1; // [RULE_14]
   wire shift_right_pulse = shift_search | shift_fwd;
   wire shift_left_pulse  = ~in_write & ~in_search & ~writers_on & reverse_direction & tp1; // [RULE_15]

   // APB decode.
   wire acc      = psel & penable;
   // Writes land only at the edge that completes the transfer, when pready is high.
   wire wr       = acc & pwrite & pready;
   wire hit_ctrl = (paddr == `TWTRS_OFF_CTRL);
   wire hit_st   = (paddr == `TWTRS_OFF_STATUS);
   wire hit_mask = (paddr == `TWTRS_OFF_MASK);
   wire hit_buf  = (paddr == `TWTRS_OFF_BUFFER);
   wire hit_sh   = (paddr == `TWTRS_OFF_SHIFT);
   wire hit_any  = hit_ctrl | hit_st | hit_mask | hit_buf | hit_sh;
   wire host_load_strobe = wr & hit_buf;                // [RULE_02]

   twtrs_xfer_if xf ();
   assign xf.load        = host_load_strobe;
   assign xf.load_data   = pwdata[17:0];
   assign xf.interchange = interchange_pulse;           // [RULE_04]
   assign xf.shift_right = shift_right_pulse;
   assign xf.shift_left  = shift_left_pulse;
   assign xf.reader_bits = rd_bits;                     // [RULE_03]

   twtrs_datapath u_path (
      .pclk    (pclk),
      .presetn (presetn),
      .xf      (xf.path)
   );

   // Flags set by hardware win over a write-one clear in the same cycle.
   wire [1:0] st_set = {raise_block_flag_pulse, raise_data_flag_pulse}; // [RULE_16]
   wire [1:0] st_clr = (wr & hit_st) ? pwdata[1:0] : 2'b00;
   wire [1:0] st_nxt = st_set | (status_r & ~st_clr);

   // Read mux; the buffer is the host's view of the assembled word. [RULE_05]
   wire [31:0] rd_mux = hit_ctrl ? {28'h000_0000, ctrl_r} :
                        hit_st   ? {30'h0000_0000, status_r} :
                        hit_mask ? {30'h0000_0000, mask_r} :
                        hit_buf  ? {14'h0000, xf.buffer_word} :
                        hit_sh   ? {14'h0000, xf.shift_word} : 32'h0000_0000;

   // Writers take the channel ends toward the active shift direction.
   wire [2:0] wr_nxt = in_write ? (reverse_direction ? xf.shift_word[17:15]
                                                     : xf.shift_word[2:0]) : 3'b000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r      <= 4'h0;
         status_r    <= 2'b00;
         mask_r      <= 2'b00;
         prdata      <= 32'h0000_0000;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         irq         <= 1'b0;
         writer_bits <= 3'b000;
      end else begin
         if (wr & hit_ctrl) ctrl_r <= pwdata[3:0];
         if (wr & hit_mask) mask_r <= pwdata[1:0];
         status_r    <= st_nxt;                          // [RULE_16] [RULE_12]
         // One wait state: pready rises in the cycle after the access phase begins.
         pready      <= psel & penable & ~pready;
         pslverr     <= psel & penable & ~pready & ~hit_any;
         prdata      <= (psel & ~pwrite) ? rd_mux : 32'h0000_0000;
         irq         <= |(st_nxt & mask_r);
         writer_bits <= wr_nxt;
      end
   end
endmodule

// ---- tb/twtrs_checker.sv ----
`timescale 1ns/1ps
module twtrs_checker (
   // Watched ports.
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_ONE_WAIT: assert property ($rose(penable) && psel |=> pready)
      else $error("ready late after first access");
   AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
      else $error("ready without access");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_ERR_READY: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_UNMAPPED: assert property (pready && (paddr > 32'h0000_0010 || paddr[1:0] != 2'b00)
      |-> pslverr) else $error("unmapped address not refused");
   AST_MAPPED: assert property (pready && paddr <= 32'h0000_0010 && paddr[1:0] == 2'b00
      |-> !pslverr) else $error("mapped address refused");
   AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("refused read not zero");
   AST_MASK_OFF: assert property (psel && penable && pwrite && pready &&
      paddr == 32'h0000_0008 && pwdata[1:0] == 2'b00 |-> ##2 !irq [*2])
      else $error("irq with mask cleared");
endmodule
bind twtrs_top twtrs_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq));

// ---- tb/twtrs_tape_model.sv ----
`timescale 1ns/1ps
module twtrs_tape_model (
   // Clock and writers.
   input  wire logic       pclk,
   input  wire logic [2:0] writer_bits,
   // Timing, marks and reader.
   output logic            time_pulse_1,
   output logic            time_pulse_2,
   output logic [3:0]      marks,
   output logic [2:0]      reader_bits
);
   logic       busy = 1'b0;
   logic [2:0] rb_q = 3'h0;
   initial begin
      time_pulse_1 = 1'b0;
      time_pulse_2 = 1'b0;
      marks = 4'h0;
      reader_bits = 3'h0;
   end
   // Outside a pulse the reader holds no valid bit, so it toggles to expose stale use.
   always @(posedge pclk) begin
      reader_bits <= busy ? rb_q : ~reader_bits;
   end
   task automatic pulse(input logic second, input logic [3:0] m, input logic [2:0] rb);
      @(posedge pclk);
      busy <= 1'b1;
      rb_q <= rb;
      marks <= m;
      repeat (2) @(posedge pclk);
      time_pulse_1 <= !second;
      time_pulse_2 <= second;
      repeat (4) @(posedge pclk);
      time_pulse_1 <= 1'b0;
      time_pulse_2 <= 1'b0;
      repeat (4) @(posedge pclk);
      busy <= 1'b0;
      marks <= 4'h0;
   endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "twtrs_consts.svh"
`define TB_CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
   $display("wrong value at %0t: readback differs", $time); end end
module tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, irq, tp1, tp2, er;
   logic [3:0]  mk, ctl;
   logic [2:0]  rbits, wbits;
   logic [17:0] bufm, shm;
   logic [1:0]  stm, mskm;
   int          fail_count = 0;
   int          check_count = 0;
   int          cyc = 0;
   always #20 pclk = ~pclk;
   twtrs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .time_pulse_1(tp1), .time_pulse_2(tp2), .block_mark(mk[0]),
      .read_data_mark(mk[1]), .write_data_mark(mk[2]), .check_mark(mk[3]),
      .reader_bits(rbits), .writer_bits(wbits), .irq(irq));
   twtrs_tape_model u_tape (.pclk(pclk), .writer_bits(wbits), .time_pulse_1(tp1),
      .time_pulse_2(tp2), .marks(mk), .reader_bits(rbits));
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // The wait ends when pready rises; if it never does, only the bench timeout ends it.
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk_all();
      apb(0, `TWTRS_OFF_BUFFER, 0);
      `TB_CHK(rd[17:0], bufm)
      apb(0, `TWTRS_OFF_SHIFT, 0);
      `TB_CHK(rd[17:0], shm)
      apb(0, `TWTRS_OFF_STATUS, 0);
      `TB_CHK(rd[1:0], stm)
      `TB_CHK(irq, |(stm & mskm))
      `TB_CHK(wbits, ctl[1:0] != twtrs_pkg::TWTRS_WRITE ? 3'b000 : ctl[3] ? shm[17:15] : shm[2:0])
   endtask
   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      {bufm, shm, stm, mskm, ctl} = '0;
      apb(0, `TWTRS_OFF_CTRL, 0);
      `TB_CHK(rd[3:0], 4'h0)
      chk_all();
   endtask
   task automatic step();
      logic [2:0] rb;
      logic [3:0] m;
      logic       s, d, b;
      logic [1:0] c;
      ctl = 4'($urandom);
      apb(1, `TWTRS_OFF_CTRL, {28'h0, ctl});
      c = 2'($urandom);
      apb(1, `TWTRS_OFF_STATUS, {30'h0, c});
      stm &= ~c;
      mskm = 2'($urandom);
      apb(1, `TWTRS_OFF_MASK, {30'h0, mskm});
      if ($urandom % 3 == 0) begin
         bufm = 18'($urandom);
         apb(1, `TWTRS_OFF_BUFFER, {14'h0, bufm});
      end
      rb = 3'($urandom);
      m = 4'h1 << ($urandom % 4);
      s = 1'($urandom);
      u_tape.pulse(s, s ? m : 4'h0, rb);
      if (!s && !ctl[2] && ctl[1:0] != twtrs_pkg::TWTRS_WRITE) begin
         if (ctl[1:0] == twtrs_pkg::TWTRS_SEARCH || !ctl[3]) shm = {rb, shm[17:3]};
         else shm = {shm[14:0], rb};
      end
      d = ctl[1:0] == twtrs_pkg::TWTRS_SEARCH && m[0] || ctl[1:0] == twtrs_pkg::TWTRS_READ &&
         m[1] || ctl[1:0] == twtrs_pkg::TWTRS_WRITE && m[2];
      b = ctl[1:0] == twtrs_pkg::TWTRS_READ && m[3];
      if (s && (d || b)) {bufm, shm} = {shm, bufm};
      if (s) stm |= {b, d};
      chk_all();
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      void'($urandom(32'h1719b6d1));
      do_reset();
      apb(1, 32'h0000_0040, 32'h0003_FFFF);
      apb(0, 32'h0000_0040, 0);
      `TB_CHK({er, rd}, {1'b1, 32'h0000_0000})
      $display("test reset and refusal done");
      repeat (60) step();
      $display("test random transfers done");
      do_reset();
      repeat (10) step();
      $display("test second reset done");
      finish_test();
   end
endmodule
